// *** verilog/fcb_host.sv ***
/*
 Host controller that drives a bulk-erase flash through its strobes,
 address and data pins, issuing command writes and read cycles.
 Assumes the flash pins are wired directly and the supply qualifiers
 are switched by this block's outputs.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Identifier read: other address low, supply low.
// - Write needs select, strobe low, enable high.
// - Host ends erase with erase verify.
// - Host programs all bytes zero first.
module fcb_host #(
   parameter int STROBE_CYC  = fcb_pkg::STROBE_CYC,
   parameter int RECOVER_CYC = fcb_pkg::RECOVER_CYC
) (
   input  wire logic             mclk,
   input  wire logic             reset,
   input  wire fcb_pkg::fcb_req_t reqIn,
   input  wire logic             reqValid,
   output logic                  reqReady,
   output logic [7:0]            rspData,
   output logic                  rspValid,
   output logic                  rspParityOk,
   output logic                  chipSelectN,
   output logic                  outputEnableN,
   output logic                  writeStrobeN,
   output logic [fcb_pkg::ADDR_W-1:0] addrOut,
   output logic [7:0]            dataOut,
   output logic                  dataOe,
   input  wire logic [7:0]       dataIn,
   output logic                  programSupplyHigh,
   output logic                  idVoltagePresent
);
   // The read window loads STROBE_CYC plus three into an 8-bit counter, so STROBE_CYC stops at 252.
   if (STROBE_CYC < 1 || STROBE_CYC > 252 || RECOVER_CYC < 1 || RECOVER_CYC > 255) begin : g_badCycles
      $error("fcb_host: cycle counts out of range");
   end
   // ------------------------------------------------------------
   // State and datapath
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_WSET  = 3'b001,
      ST_WLOW  = 3'b010,
      ST_WHIGH = 3'b011,
      ST_RLOW  = 3'b100,
      ST_RDONE = 3'b101
   } fcb_state_t;
   fcb_state_t                state_ff, nxt_state;
   fcb_pkg::fcb_req_t         req_ff;
   logic [7:0]                cnt_ff;
   logic [1:0]                step_ff;
   logic [7:0]                dataSync;
   fcb_sync #(.W(8)) u_sync (
      .mclk  (mclk),
      .reset (reset),
      .din   (dataIn),
      .dout  (dataSync)
   );
   function automatic logic [7:0] fcbCmd(input fcb_pkg::fcb_op_t op);
      case (op)
         fcb_pkg::FCB_OP_RDMODE:  fcbCmd = fcb_pkg::CMD_READ;
         fcb_pkg::FCB_OP_ESETUP:  fcbCmd = fcb_pkg::CMD_ERASE;
         fcb_pkg::FCB_OP_EVERIFY: fcbCmd = fcb_pkg::CMD_EVERIFY;
         fcb_pkg::FCB_OP_PROGRAM: fcbCmd = fcb_pkg::CMD_PSETUP;
         fcb_pkg::FCB_OP_PVERIFY: fcbCmd = fcb_pkg::CMD_PVERIFY;
         fcb_pkg::FCB_OP_ID:      fcbCmd = fcb_pkg::CMD_ID;
         default:                 fcbCmd = fcb_pkg::CMD_RESET;
      endcase
   endfunction
   // Decode from the request being taken, so the first write never sets up stale fields.
   wire                    accept = reqValid && reqReady;
   wire fcb_pkg::fcb_req_t curReq = accept ? reqIn : req_ff;
   // Two write steps: erase and reset repeat, program follows its code with data, verify adds a read.
   wire       twoWrites  = (curReq.op == fcb_pkg::FCB_OP_ESETUP) ||
                           (curReq.op == fcb_pkg::FCB_OP_PROGRAM) ||
                           (curReq.op == fcb_pkg::FCB_OP_RESET);
   wire       wantsRead  = (curReq.op == fcb_pkg::FCB_OP_READ) ||
                           (curReq.op == fcb_pkg::FCB_OP_ID) ||
                           (curReq.op == fcb_pkg::FCB_OP_EVERIFY) ||
                           (curReq.op == fcb_pkg::FCB_OP_PVERIFY);
   // Id reads run with the supply low, where a write would be ignored, so they skip it.
   wire       hasWrite   = (curReq.op != fcb_pkg::FCB_OP_READ) && (curReq.op != fcb_pkg::FCB_OP_ID);
   wire       secondStep = (step_ff == 2'd1);
   wire       secondWrite = (state_ff == ST_WHIGH);
   // Second program write carries the target address and data; others send codes.
   wire [7:0] wrData     = (secondWrite && curReq.op == fcb_pkg::FCB_OP_PROGRAM) ? curReq.data
                           : fcbCmd(curReq.op);
   wire       cntDone    = (cnt_ff == 8'h00);
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE:  if (accept) nxt_state = ST_WSET;
         ST_WSET:  nxt_state = hasWrite ? ST_WLOW : ST_RLOW;
         ST_WLOW:  if (cntDone) nxt_state = ST_WHIGH;
         ST_WHIGH: if (cntDone) begin
            if (twoWrites && !secondStep) nxt_state = ST_WSET;
            else if (wantsRead) nxt_state = ST_RLOW;
            else nxt_state = ST_IDLE;
         end
         ST_RLOW:  if (cntDone) nxt_state = ST_RDONE;
         ST_RDONE: nxt_state = ST_IDLE;
         default:  nxt_state = ST_IDLE;
      endcase
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (reset) begin
         state_ff          <= ST_IDLE;
         req_ff            <= '0;
         cnt_ff            <= 8'h00;
         step_ff           <= 2'd0;
         reqReady          <= 1'b0;
         rspData           <= 8'h00;
         rspValid          <= 1'b0;
         rspParityOk       <= 1'b0;
         chipSelectN       <= 1'b1;
         outputEnableN     <= 1'b1;
         writeStrobeN      <= 1'b1;
         addrOut           <= '0;
         dataOut           <= 8'h00;
         dataOe            <= 1'b0;
         programSupplyHigh <= 1'b0;
         idVoltagePresent  <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         reqReady <= (nxt_state == ST_IDLE) && !accept;
         rspValid <= 1'b0;
         if (accept) begin
            req_ff  <= reqIn;
            step_ff <= 2'd0;
            // Supply high for command writes; low with raised id level for id reads.
            programSupplyHigh <= (reqIn.op != fcb_pkg::FCB_OP_ID);
            idVoltagePresent  <= (reqIn.op == fcb_pkg::FCB_OP_ID);
         end
         case (nxt_state)
            ST_WSET: begin
               // Output enable high and select low before the strobe falls.
               chipSelectN   <= 1'b0;
               outputEnableN <= 1'b1;
               writeStrobeN  <= 1'b1;
               addrOut       <= (curReq.op == fcb_pkg::FCB_OP_ID) ? '0 : curReq.addr;
               dataOut       <= wrData;
               dataOe        <= hasWrite;
               cnt_ff        <= 8'(STROBE_CYC - 1);
               if (state_ff == ST_WHIGH) step_ff <= 2'd1;
            end
            ST_WLOW: begin
               writeStrobeN <= 1'b0;
            end
            ST_WHIGH: begin
               // Data is taken at this rise; erase starts or stops here.
               if (state_ff == ST_WLOW) begin
                  writeStrobeN <= 1'b1;
                  cnt_ff       <= 8'(RECOVER_CYC - 1);
               end
            end
            ST_RLOW: begin
               if (state_ff != ST_RLOW) begin
                  // Id reads hold all but the lsb low; verifies ignore the address.
                  addrOut       <= (req_ff.op == fcb_pkg::FCB_OP_ID) ?
                                   {{(fcb_pkg::ADDR_W-1){1'b0}}, req_ff.addr[0]} : req_ff.addr;
                  dataOe        <= 1'b0;
                  chipSelectN   <= 1'b0;
                  outputEnableN <= 1'b0;
                  cnt_ff        <= 8'(STROBE_CYC + 3);
               end
            end
            ST_RDONE: begin
               rspData       <= dataSync;
               rspParityOk   <= ^dataSync;
               rspValid      <= 1'b1;
               outputEnableN <= 1'b1;
            end
            default: begin
               // Deselect between operations; the device keeps erasing meanwhile.
               chipSelectN   <= 1'b1;
               outputEnableN <= 1'b1;
               dataOe        <= 1'b0;
            end
         endcase
         if (nxt_state == state_ff && !cntDone) cnt_ff <= cnt_ff - 8'h01;
         if (state_ff == ST_WHIGH && nxt_state == ST_WHIGH && cntDone) cnt_ff <= 8'h00;
      end
   end
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Counts the low cycles of the write strobe, so its width is checked for any STROBE_CYC.
   logic [7:0] weLowCnt_ff;
   always_ff @(posedge mclk) begin
      if (reset || writeStrobeN) begin
         weLowCnt_ff <= 8'h00;
      end else if (weLowCnt_ff != 8'hFF) begin
         weLowCnt_ff <= weLowCnt_ff + 8'h01;
      end
   end
   a_no_contention: assert property (@(posedge mclk) disable iff (reset)
      dataOe |-> outputEnableN) else $error("host drives data while output enabled");
   a_write_select: assert property (@(posedge mclk) disable iff (reset)
      !writeStrobeN |-> !chipSelectN && outputEnableN) else $error("bad write strobe");
   a_data_stable: assert property (@(posedge mclk) disable iff (reset)
      (!writeStrobeN ##1 writeStrobeN) |-> $stable(dataOut)) else $error("data moved at rise");
   a_read_select: assert property (@(posedge mclk) disable iff (reset)
      !outputEnableN |-> !chipSelectN && !dataOe) else $error("read without select");
   a_id_lines: assert property (@(posedge mclk) disable iff (reset)
      (idVoltagePresent && !outputEnableN) |-> addrOut[fcb_pkg::ADDR_W-1:1] == '0 && !programSupplyHigh)
      else $error("id read address high");
   a_write_supply: assert property (@(posedge mclk) disable iff (reset)
      !writeStrobeN |-> programSupplyHigh) else $error("write without supply");
   a_resp_pulse: assert property (@(posedge mclk) disable iff (reset)
      rspValid |=> !rspValid) else $error("response not a pulse");
   a_strobe_width: assert property (@(posedge mclk) disable iff (reset)
      $rose(writeStrobeN) |-> weLowCnt_ff == 8'(STROBE_CYC)) else $error("write strobe width wrong");
   c_erase: cover property (@(posedge mclk) accept && reqIn.op == fcb_pkg::FCB_OP_ESETUP);
   c_program: cover property (@(posedge mclk) accept && reqIn.op == fcb_pkg::FCB_OP_PROGRAM);
   c_id: cover property (@(posedge mclk) rspValid && idVoltagePresent);
endmodule // fcb_host
`default_nettype wire

// *** verilog/fcb_pkg.sv ***
/*
 Package for the flash command bus host controller: command codes,
 timing counts and the request and pin carrier types.
 Assumes a 25 MHz system clock.
*/
`default_nettype none
package fcb_pkg;
   localparam int          CLK_MHZ       = 25;
   localparam int          ADDR_W        = 15;
   // ------------------------------------------------------------
   // Command codes
   // ------------------------------------------------------------
   localparam logic [7:0]  CMD_READ      = 8'h00;
   localparam logic [7:0]  CMD_RESET     = 8'hFF;
   localparam logic [7:0]  CMD_ID        = 8'h90;
   localparam logic [7:0]  CMD_ERASE     = 8'h20;
   localparam logic [7:0]  CMD_EVERIFY   = 8'hA0;
   localparam logic [7:0]  CMD_PSETUP    = 8'h40;
   localparam logic [7:0]  CMD_PVERIFY   = 8'hC0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int          STROBE_NS     = 120;
   localparam int          STROBE_CYC    = (STROBE_NS * CLK_MHZ + 999) / 1000;
   localparam int          RECOVER_NS    = 6000;
   localparam int          RECOVER_CYC   = (RECOVER_NS * CLK_MHZ + 999) / 1000;
   // ------------------------------------------------------------
   // Operations requested by the user side
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      FCB_OP_READ    = 3'b000,
      FCB_OP_ID      = 3'b001,
      FCB_OP_RDMODE  = 3'b010,
      FCB_OP_ESETUP  = 3'b011,
      FCB_OP_EVERIFY = 3'b100,
      FCB_OP_PROGRAM = 3'b101,
      FCB_OP_PVERIFY = 3'b110,
      FCB_OP_RESET   = 3'b111
   } fcb_op_t;
   typedef struct packed {
      fcb_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          data;
   } fcb_req_t;
   typedef struct packed {
      logic                chipSelectN;
      logic                outputEnableN;
      logic                writeStrobeN;
      logic [ADDR_W-1:0]   addr;
      logic [7:0]          dataOut;
      logic                dataOe;
   } fcb_pins_t;
endpackage
`default_nettype wire

// *** verilog/fcb_sync.sv ***
/*
 Three-stage synchroniser for pin inputs with agreement filter.
 Assumes the inputs are asynchronous to mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module fcb_sync #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         reset,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] nxt_dout;
   // The output only changes once the second and third stages agree on every bit.
   assign nxt_dout = (s2_ff == s3_ff) ? s3_ff : dout;
   always_ff @(posedge mclk) begin
      if (reset) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         dout  <= '0;
      end else begin
         s1_ff <= din;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         dout  <= nxt_dout;
      end
   end
endmodule // fcb_sync
`default_nettype wire

// *** tb/fcb_flash_model.sv ***
/*
 Behavioural model of the bulk-erase flash that the host drives.
 Assumes the pins come straight from fcb_host with no delay.
*/
`timescale 1ns/1ps
`default_nettype none
module fcb_flash_model #(
   parameter logic [7:0] MFR_ID = 8'h07, // Arbitrary value with odd parity.
   parameter logic [7:0] DEV_ID = 8'h8F  // Arbitrary value with odd parity.
) (
   input  wire logic                       chipSelectN,
   input  wire logic                       outputEnableN,
   input  wire logic                       writeStrobeN,
   input  wire logic [fcb_pkg::ADDR_W-1:0] addr,
   input  wire logic [7:0]                 hostData,
   input  wire logic                       hostOe,
   input  wire logic                       supplyHigh,
   input  wire logic                       idVoltage,
   output logic      [7:0]                 dataOut,
   output logic                            protoErr
);
   logic [7:0]                 mem [0:(1<<fcb_pkg::ADDR_W)-1];
   logic [7:0]                 cmd;
   logic [7:0]                 lastOut;
   logic [fcb_pkg::ADDR_W-1:0] latA;
   logic [fcb_pkg::ADDR_W-1:0] pa;
   logic [fcb_pkg::ADDR_W-1:0] va;
   logic                       armed;
   logic                       erasing;
   logic                       pset;
   wire                        drive = !chipSelectN && !outputEnableN;
   // The command latch is never returned by a read, so it has no address.
   wire logic [7:0] rd = ((idVoltage && !supplyHigh) || cmd == 8'h80 || cmd == 8'h90) ?
      (addr[0] ? DEV_ID : MFR_ID) :
      (cmd == 8'hA0) ? mem[va] : (cmd == 8'hC0) ? mem[pa] : mem[addr];
   initial begin
      cmd = 8'h00;
      armed = 1'b0;
      erasing = 1'b0;
      pset = 1'b0;
      protoErr = 1'b0;
      lastOut = 8'h00;
      for (int i = 0; i < (1<<fcb_pkg::ADDR_W); i++) mem[i] = 8'h00;
   end
   // A released bus shows the inverse of its last value, never a held copy.
   always @(drive or rd) begin
      if (drive) begin
         dataOut = rd;
         lastOut = rd;
      end else dataOut = ~lastOut;
   end
   always @(supplyHigh) begin
      cmd = 8'h00;
      armed = 1'b0;
      pset = 1'b0;
   end
   always @(negedge outputEnableN) if (idVoltage && (supplyHigh || addr[14:1] != 0)) protoErr = 1'b1;
   always @(negedge writeStrobeN) begin
      if (!chipSelectN && outputEnableN) latA = addr;
      if (!outputEnableN) protoErr = 1'b1;
   end
   // Erase runs on regardless of chip select; only the verify write ends it.
   always @(posedge writeStrobeN) begin
      if (!chipSelectN && outputEnableN && supplyHigh) begin
         if (!hostOe) protoErr = 1'b1;
         if (pset) begin
            pa = latA;
            mem[latA] = hostData;
            pset = 1'b0;
            cmd = 8'h40;
         end else begin
            if (hostData == 8'hA0 && erasing) begin
               for (int i = 0; i < (1<<fcb_pkg::ADDR_W); i++) mem[i] = 8'hFF;
            end
            if (hostData == 8'hA0) va = latA;
            if (hostData == 8'hA0) erasing = 1'b0;
            if (hostData == 8'h20 && armed) begin
               // Erase is only even across the cells when every byte already holds zero.
               for (int i = 0; i < (1<<fcb_pkg::ADDR_W); i++) if (mem[i] != 8'h00) protoErr = 1'b1;
               erasing = 1'b1;
            end
            armed = (hostData == 8'h20) && !armed;
            pset = (hostData == 8'h40);
            cmd = (hostData == 8'hFF && cmd == 8'hFF) ? 8'h00 : hostData;
         end
      end
   end
endmodule // fcb_flash_model
`default_nettype wire

// *** tb/tb.sv ***
/*
 Self-checking bench for fcb_host against the flash model.
 Assumes short strobe and recovery counts are safe for the model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                       mclk = 1'b0;
   logic                       reset = 1'b1;
   logic                       reqValid = 1'b0;
   fcb_pkg::fcb_req_t          reqIn = '0;
   logic                       reqReady, rspValid, rspParityOk, csN, oeN, weN, dOe, vpp, vid, protoErr;
   logic [7:0]                 rspData, dOut, dIn, rsp, d;
   logic                       par, gotRsp;
   logic [fcb_pkg::ADDR_W-1:0] aOut, a, b;
   logic [7:0]                 refMem [0:(1<<fcb_pkg::ADDR_W)-1];
   int                         err_count = 0;
   int                         n_compared = 0;
   int                         seed = 36;
   always #20 mclk = ~mclk;
   fcb_host #(.STROBE_CYC(1), .RECOVER_CYC(2)) dut_u (.mclk(mclk), .reset(reset), .reqIn(reqIn),
      .reqValid(reqValid), .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid),
      .rspParityOk(rspParityOk), .chipSelectN(csN), .outputEnableN(oeN), .writeStrobeN(weN),
      .addrOut(aOut), .dataOut(dOut), .dataOe(dOe), .dataIn(dIn), .programSupplyHigh(vpp),
      .idVoltagePresent(vid));
   fcb_flash_model flash_u (.chipSelectN(csN), .outputEnableN(oeN), .writeStrobeN(weN), .addr(aOut),
      .hostData(dOut), .hostOe(dOe), .supplyHigh(vpp), .idVoltage(vid), .dataOut(dIn), .protoErr(protoErr));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   function automatic logic [7:0] exp_id(input logic lsb);
      return lsb ? 8'h8F : 8'h07;
   endfunction
   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t byte %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   task automatic run_op(input fcb_pkg::fcb_op_t op, input logic [14:0] ad, input logic [7:0] dd);
      int n;
      reqIn <= '{op: op, addr: ad, data: dd};
      reqValid <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (reqReady === 1'b1) break;
      end
      reqValid <= 1'b0;
      if (n == 50) begin
         err_count++;
         $display("[ERR] %0t request not taken", $time);
      end
      gotRsp = 1'b0;
      for (n = 0; n < 400; n++) begin
         @(posedge mclk);
         if (rspValid === 1'b1) begin
            rsp = rspData;
            par = rspParityOk;
            gotRsp = 1'b1;
         end
         if (reqReady === 1'b1) break;
      end
      if (n == 400) begin
         err_count++;
         $display("[ERR] %0t operation never finished", $time);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   initial begin
      for (int i = 0; i < (1<<fcb_pkg::ADDR_W); i++) refMem[i] = 8'h00;
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 2; i++) begin
         run_op(fcb_pkg::FCB_OP_ID, 15'(i), 8'h00);
         check_bit(gotRsp, 1'b1);
         check_byte(rsp, exp_id(i[0]));
         check_bit(par, 1'b1);
      end
      $display("test identifier done");
      for (int i = 0; i < 6; i++) begin
         a = 15'($random(seed));
         d = 8'($random(seed));
         b = 15'($random(seed));
         if (i < 2) a = i[0] ? 15'h0000 : 15'h7FFF;
         if (i < 2) d = i[0] ? 8'h00 : 8'hFF;
         run_op(fcb_pkg::FCB_OP_PROGRAM, a, d);
         refMem[a] = d;
         run_op(fcb_pkg::FCB_OP_PVERIFY, ~a, 8'h00);
         check_byte(rsp, d);
         run_op(fcb_pkg::FCB_OP_RDMODE, 15'h0000, 8'h00);
         run_op(fcb_pkg::FCB_OP_READ, b, 8'h00);
         check_byte(rsp, refMem[b]);
         run_op(fcb_pkg::FCB_OP_READ, a, 8'h00);
         check_byte(rsp, d);
      end
      $display("test program done");
      for (int i = 0; i < (1<<fcb_pkg::ADDR_W); i++) begin
         if (refMem[i] != 8'h00) begin
            run_op(fcb_pkg::FCB_OP_PROGRAM, 15'(i), 8'h00);
            refMem[i] = 8'h00;
         end
      end
      run_op(fcb_pkg::FCB_OP_ESETUP, 15'h0000, 8'h00);
      run_op(fcb_pkg::FCB_OP_EVERIFY, a, 8'h00);
      check_byte(rsp, 8'hFF);
      run_op(fcb_pkg::FCB_OP_PROGRAM, b, 8'h3C);
      run_op(fcb_pkg::FCB_OP_PVERIFY, 15'h0000, 8'h00);
      run_op(fcb_pkg::FCB_OP_RESET, 15'h0000, 8'h00);
      run_op(fcb_pkg::FCB_OP_READ, b, 8'h00);
      check_byte(rsp, 8'h3C);
      run_op(fcb_pkg::FCB_OP_READ, ~b, 8'h00);
      check_byte(rsp, 8'hFF);
      $display("test erase done");
      check_bit(protoErr, 1'b0);
      finish_test();
   end
   initial begin
      #(40 * 20000);
      err_count++;
      $display("[ERR] %0t watchdog expired", $time);
      finish_test();
   end
endmodule // tb
`default_nettype wire
